//--- logic/ubg_baud_gen.sv
// What this block does
// - An 8-bit prescale select register; low four bits pick the base clock.
// - Prescale select resets to zero, so base clock is the main clock.
// - Code m from 0 to 10 divides the main clock by two to m.
// - The divisor register resets to all ones, divisor 255.
// - Baud clock is the serial clock halved.
// - Serial clock is base clock divided by k; k from 4 to 255.
// - Baud rate equals main clock over two to m plus one times k.
// - The divisor is read and written as a whole byte; prescale select keeps only its low four bits.
// - Base clock reaches the divisor counters only while power is on.
// - Separate transmit and receive divisor counters share one divisor setting.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module ubg_baud_gen #(
  parameter int ADDR_W = ubg_pkg::ADDR_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic tx_baud_clk_q,
  output logic tx_baud_tick_q,
  output logic rx_baud_clk_q,
  output logic rx_baud_tick_q
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] A_CTRL = ADDR_W'({ubg_pkg::IDX_CHANNEL_CONTROL_REG, 2'b00});
  localparam logic [ADDR_W-1:0] A_PSEL = ADDR_W'({ubg_pkg::IDX_BASE_CLOCK_PRESCALE_SELECT, 2'b00});
  localparam logic [ADDR_W-1:0] A_DIV = ADDR_W'({ubg_pkg::IDX_BAUD_DIVISOR, 2'b00});
  localparam logic [ADDR_W-1:0] A_STAT = ADDR_W'({ubg_pkg::IDX_BAUD_STATUS, 2'b00});

  // Width of the free-running prescaler count, enough for the largest division.
  localparam int PRESCALE_W = ubg_pkg::PRESCALE_CNT_W;

  logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_d, rvalid_d;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic [7:0] ctrl_q, psel_q, div_q;
  logic [PRESCALE_W-1:0] pcnt_q;
  logic base_tick_q;

  // Address matches for the held write address and the live read address.
  wire aw_is_ctrl = (awaddr_q == A_CTRL);
  wire aw_is_psel = (awaddr_q == A_PSEL);
  wire aw_is_div = (awaddr_q == A_DIV);
  wire aw_is_stat = (awaddr_q == A_STAT);
  wire ar_is_ctrl = (s_axi_araddr == A_CTRL);
  wire ar_is_psel = (s_axi_araddr == A_PSEL);
  wire ar_is_div = (s_axi_araddr == A_DIV);
  wire ar_is_stat = (s_axi_araddr == A_STAT);

  // Write is performed once both address and data are held.
  wire do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  // A write with lane 0 off is answered but leaves every register as it was.
  wire wr_ctrl = do_write && wlane_q && aw_is_ctrl;
  wire wr_psel = do_write && wlane_q && aw_is_psel;
  wire wr_div = do_write && wlane_q && aw_is_div;
  // The status register is read-only: a write to it is answered but changes nothing.
  wire wr_hit = aw_is_ctrl || aw_is_psel || aw_is_div || aw_is_stat;
  wire rd_hit = ar_is_ctrl || ar_is_psel || ar_is_div || ar_is_stat;

  // Handshake next states; ready flags register their inverses, the write ones also low while a response is due.
  assign aw_have_d = aw_have_q ? !do_write : aw_take;
  assign w_have_d = w_have_q ? !do_write : w_take;
  assign bvalid_d = s_axi_bvalid ? !s_axi_bready : do_write;
  assign rvalid_d = s_axi_rvalid ? !s_axi_rready : ar_take;

  // ----------------------------------------------------------------
  // Settings view
  // ----------------------------------------------------------------
  // Named views of the setting fields that steer the prescaler and counters.
  ubg_pkg::ubg_cfg_s cfg;
  assign cfg.channel_power_bit = ctrl_q[ubg_pkg::POS_CHANNEL_POWER];
  assign cfg.transmit_enable_bit = ctrl_q[ubg_pkg::POS_TRANSMIT_ENABLE];
  assign cfg.receive_enable_bit = ctrl_q[ubg_pkg::POS_RECEIVE_ENABLE];
  assign cfg.prescale_code = psel_q[ubg_pkg::PRESCALE_CODE_W-1:0];
  assign cfg.divisor_k = div_q;

  // Read data selection; reserved bits read as zero.
  wire [7:0] stat_byte = {5'h00, rx_baud_clk_q, tx_baud_clk_q, cfg.channel_power_bit};
  wire [7:0] rd_byte = ar_is_ctrl ? ctrl_q :
                       ar_is_psel ? {4'h0, psel_q[3:0]} :
                       ar_is_div ? div_q :
                       ar_is_stat ? stat_byte : 8'h00;

  // ----------------------------------------------------------------
  // Bus handshake registers
  // ----------------------------------------------------------------
  // Address and data channels are accepted independently, in either order.
  // A ready flag drops after its channel is taken and returns only once the response is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      s_axi_awready <= !aw_have_d && !bvalid_d;
      s_axi_wready <= !w_have_d && !bvalid_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_arready <= !rvalid_d;
      s_axi_rvalid <= rvalid_d;
    end
  end

  // Captured request payloads and answers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_q <= '0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
      s_axi_bresp <= ubg_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= ubg_pkg::RESP_OKAY;
    end else begin
      if (aw_take) awaddr_q <= s_axi_awaddr;
      if (w_take) begin
        wbyte_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
      end
      if (do_write) s_axi_bresp <= wr_hit ? ubg_pkg::RESP_OKAY : ubg_pkg::RESP_DECERR;
      if (ar_take) begin
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_hit ? ubg_pkg::RESP_OKAY : ubg_pkg::RESP_DECERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Setting registers
  // ----------------------------------------------------------------
  // Software must stop the channel before rewriting the settings; this logic
  // takes a write at any time and relies on that ordering.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= ubg_pkg::RST_CHANNEL_CONTROL;
      psel_q <= ubg_pkg::RST_PRESCALE_SELECT;
      div_q <= ubg_pkg::RST_BAUD_DIVISOR;
    end else begin
      // Only power and the two enables are kept; the other control bits read zero.
      if (wr_ctrl) ctrl_q <= {wbyte_q[7:5], 5'h00};
      if (wr_psel) psel_q <= {4'h0, wbyte_q[3:0]};
      if (wr_div) div_q <= wbyte_q;
    end
  end

  // ----------------------------------------------------------------
  // Base clock prescaler
  // ----------------------------------------------------------------
  // Prohibited codes above the maximum act as the maximum.
  wire [3:0] code_eff = (cfg.prescale_code > ubg_pkg::PRESCALE_CODE_MAX) ? ubg_pkg::PRESCALE_CODE_MAX :
                        cfg.prescale_code;
  wire [PRESCALE_W-1:0] pmask = PRESCALE_W'((11'h001 << code_eff) - 11'h001);
  // A tick every two to the m main clocks, giving the base clock.
  wire base_tick_d = cfg.channel_power_bit && ((pcnt_q & pmask) == pmask);

  // The prescaler runs and the base clock is issued only while powered.
  // The base tick is registered, so both counters see it one cycle late;
  // they share it, so the lag is equal and no period is changed by it.
  always_ff @(posedge aclk) begin
    if (!aresetn || !cfg.channel_power_bit) begin
      pcnt_q <= '0;
      base_tick_q <= 1'b0;
    end else begin
      pcnt_q <= pcnt_q + PRESCALE_W'(1);
      base_tick_q <= base_tick_d;
    end
  end

  // ----------------------------------------------------------------
  // Transmit and receive divisor counters
  // ----------------------------------------------------------------
  // Two independent counters fed by the same base clock and divisor.
  // Each counter clears itself whenever power or its own enable is off.
  ubg_divisor_counter #(.CNT_W(8)) u_tx_counter (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(cfg.channel_power_bit && cfg.transmit_enable_bit),
    .base_tick(base_tick_q),
    .divisor_k(cfg.divisor_k),
    .baud_clk_q(tx_baud_clk_q),
    .baud_tick_q(tx_baud_tick_q)
  );

  ubg_divisor_counter #(.CNT_W(8)) u_rx_counter (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(cfg.channel_power_bit && cfg.receive_enable_bit),
    .base_tick(base_tick_q),
    .divisor_k(cfg.divisor_k),
    .baud_clk_q(rx_baud_clk_q),
    .baud_tick_q(rx_baud_tick_q)
  );

endmodule // ubg_baud_gen

//--- inc/ubg_pkg.sv
package ubg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [31:0] IDX_CHANNEL_CONTROL_REG = 32'hFFFFFAA0;
  localparam logic [31:0] IDX_BASE_CLOCK_PRESCALE_SELECT = 32'hFFFFFAA1;
  localparam logic [31:0] IDX_BAUD_DIVISOR = 32'hFFFFFAA2;
  localparam logic [31:0] IDX_BAUD_STATUS = 32'hFFFFFAA3;
  localparam int ADDR_W = 12;

  // Reset values.
  localparam logic [7:0] RST_CHANNEL_CONTROL = 8'h00;
  localparam logic [7:0] RST_PRESCALE_SELECT = 8'h00;
  localparam logic [7:0] RST_BAUD_DIVISOR = 8'hFF;

  // Field positions in the channel control register.
  localparam int POS_CHANNEL_POWER = 7;
  localparam int POS_TRANSMIT_ENABLE = 6;
  localparam int POS_RECEIVE_ENABLE = 5;

  // Field positions in the status register.
  localparam int POS_ST_BASE_RUN = 0;
  localparam int POS_ST_TX_BAUD = 1;
  localparam int POS_ST_RX_BAUD = 2;

  // Prescaler code field and limits.
  localparam int PRESCALE_CODE_W = 4;
  localparam logic [3:0] PRESCALE_CODE_MAX = 4'hA;
  localparam int PRESCALE_CNT_W = 10;
  localparam logic [7:0] DIVISOR_K_MIN = 8'h04;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Settings that steer the generator.
  typedef struct packed {
    logic channel_power_bit;
    logic transmit_enable_bit;
    logic receive_enable_bit;
    logic [3:0] prescale_code;
    logic [7:0] divisor_k;
  } ubg_cfg_s;

endpackage

//--- logic/ubg_divisor_counter.sv
`timescale 1ns/1ps
module ubg_divisor_counter #(
  parameter int CNT_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic base_tick,
  input wire logic [CNT_W-1:0] divisor_k,
  output logic baud_clk_q,
  output logic baud_tick_q
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] k_eff;
  logic serial_pulse;

  // Prohibited divisors below the minimum are treated as the minimum.
  assign k_eff = (divisor_k < CNT_W'(ubg_pkg::DIVISOR_K_MIN)) ? CNT_W'(ubg_pkg::DIVISOR_K_MIN) : divisor_k;
  // One serial clock pulse every k base clock ticks.
  assign serial_pulse = run && base_tick && (cnt_q >= k_eff - CNT_W'(1));

  // Counter, baud clock halving the serial clock, and rising-edge tick.
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_q <= '0;
      baud_clk_q <= 1'b0;
      baud_tick_q <= 1'b0;
    end else begin
      if (base_tick) begin
        cnt_q <= serial_pulse ? '0 : cnt_q + CNT_W'(1);
      end
      if (serial_pulse) begin
        baud_clk_q <= ~baud_clk_q;
      end
      baud_tick_q <= serial_pulse && !baud_clk_q;
    end
  end

endmodule // ubg_divisor_counter

//--- bench/ubg_baud_gen_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker for the baud rate generator
// ----------------------------------------------------------------
module ubg_baud_gen_checker (
  input logic aclk,
  input logic aresetn,
  input logic s_axi_arready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic tx_baud_clk_q,
  input logic tx_baud_tick_q,
  input logic rx_baud_clk_q,
  input logic rx_baud_tick_q
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // A half period of the baud clock spans at least k base ticks, and k is never below four.
  sequence hold4(s);
    s [*4];
  endsequence
  sequence pulse1(s);
    s ##1 !s;
  endsequence

  // Bus answers stand until taken, and registers occupy lane 0 only.
  chk_b_stand: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response moved before it was taken");
  chk_r_stand: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved before it was taken");
  chk_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bytes not zero");
  chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while a read answer is pending");
  // Baud clock shape and its rising-edge tick.
  chk_tx_tick_rise: assert property ($rose(tx_baud_clk_q) |-> ##[0:1] tx_baud_tick_q)
    else $error("transmit tick missing at baud clock rise");
  chk_tx_tick_one: assert property (tx_baud_tick_q |-> pulse1(tx_baud_tick_q))
    else $error("transmit tick longer than one cycle");
  chk_tx_high_min: assert property ($rose(tx_baud_clk_q) |-> hold4(tx_baud_clk_q))
    else $error("transmit baud clock high phase too short");
  chk_tx_low_min: assert property ($fell(tx_baud_clk_q) |-> hold4(!tx_baud_clk_q))
    else $error("transmit baud clock low phase too short");
  chk_rx_high_min: assert property ($rose(rx_baud_clk_q) |-> hold4(rx_baud_clk_q))
    else $error("receive baud clock high phase too short");
  chk_rx_tick_rise: assert property ($rose(rx_baud_clk_q) |-> ##[0:1] rx_baud_tick_q)
    else $error("receive tick missing at baud clock rise");
endmodule // ubg_baud_gen_checker

bind ubg_baud_gen ubg_baud_gen_checker chk (.*);

//--- bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------------------------------
  // Signals, addresses and the design
  // ----------------------------------------------------------------
  localparam logic [1:0] OK = ubg_pkg::RESP_OKAY;
  localparam logic [1:0] DE = ubg_pkg::RESP_DECERR;
  localparam logic [11:0] CTL = 12'(ubg_pkg::IDX_CHANNEL_CONTROL_REG << 2);
  localparam logic [11:0] PSC = 12'(ubg_pkg::IDX_BASE_CLOCK_PRESCALE_SELECT << 2);
  localparam logic [11:0] DIV = 12'(ubg_pkg::IDX_BAUD_DIVISOR << 2);
  localparam logic [11:0] STA = 12'(ubg_pkg::IDX_BAUD_STATUS << 2);
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000, rdata, r, seed = 32'h00008C01;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, txc, txt, rxc, rxt;
  logic [1:0] bresp, rresp;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  logic [33:0] pq[$];
  int error_cnt = 0, samples_checked = 0, cnt = 0;
  int tn = 0, tm = 0, tk = 0;
  bit seen = 1'b0, sel = 1'b0;
  always #25 aclk = ~aclk;
  ubg_baud_gen dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_baud_clk_q(txc),
    .tx_baud_tick_q(txt), .rx_baud_clk_q(rxc), .rx_baud_tick_q(rxt));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic cmp(input string n, input logic [33:0] e, input logic [33:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // The response ready is raised after a random wait, so answers must stand until taken.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
    int w;
    bit done;
    bq.push_back(e);
    w = int'(xs() % 4);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (w == 0);
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      done = bvalid && bready;
      if (!done && w > 0) w--;
      if (!done && w == 0) bready <= 1'b1;
    end while (!done);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    int w;
    bit done;
    rq.push_back({e, d});
    w = int'(xs() % 4);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (w == 0);
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      done = rvalid && rready;
      if (!done && w > 0) w--;
      if (!done && w == 0) rready <= 1'b1;
    end while (!done);
    rready <= 1'b0;
  endtask
  // Stops the channel, sets code m and divisor k, then notes two full baud periods.
  task automatic run(input logic [7:0] m, input logic [7:0] k, input bit rx);
    logic [33:0] e;
    e = 34'(2 * (k < 4 ? 4 : k) * (1 << (m > 10 ? 10 : m)));
    wr(CTL, 32'h00000000, 4'h1, OK);
    wr(PSC, {24'h000000, m}, 4'h1, OK);
    wr(DIV, {24'h000000, k}, 4'h1, OK);
    sel = rx;
    seen = 1'b0;
    repeat (2) pq.push_back(e);
    wr(CTL, rx ? 32'h000000A0 : 32'h000000C0, 4'h1, OK);
    while (pq.size() > 0) @(posedge aclk);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Scoreboard: takes the oldest note off a queue whenever a result appears.
  always @(posedge aclk) begin
    if (bvalid && bready) cmp("bresp", {32'h00000000, bq.pop_front()}, {32'h00000000, bresp});
    if (rvalid && rready) cmp("read", rq.pop_front(), {rresp, rdata});
    if (sel ? rxt : txt) begin
      if (seen && pq.size() > 0) cmp("period", pq.pop_front(), 34'(cnt));
      seen = 1'b1;
      cnt = 1;
    end else cnt++;
  end
  // Main sequence.
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(PSC, 32'h00000000, OK);
    rd(DIV, 32'h000000FF, OK);
    r = xs();
    wr(PSC, {r[31:8], 8'hFA}, 4'hF, OK);
    rd(PSC, 32'h0000000A, OK);
    wr(DIV, 32'h00000033, 4'hE, OK);
    wr(12'h004, 32'h00000011, 4'h1, DE);
    rd(DIV, 32'h000000FF, OK);
    run(8'h00, 8'h04, 1'b0);
    run(8'h02, 8'h06, 1'b1);
    run(8'h0A, 8'h04, 1'b0);
    run(8'h0F, 8'h02, 1'b1);
    // Software derives m and k from a random target divisor by halving and rounding.
    r = xs();
    tn = 256 + int'(r % 768);
    tm = 0;
    while ((tn >> tm) >= 256) tm++;
    tk = (tn + ((1 << tm) >> 1)) >> tm;
    if (tk == 256) begin
      tk = 128;
      tm++;
    end
    run(8'(tm), 8'(tk), 1'b0);
    rd(STA, 32'h00000003, OK);
    wr(CTL, 32'h00000060, 4'h1, OK);
    repeat (40) @(posedge aclk);
    cmp("baud clocks unpowered", 34'h0, {32'h0, txc, rxc});
    rd(STA, 32'h00000000, OK);
    rd(CTL, 32'h00000060, OK);
    // A second reset with the channel unpowered must bring the divisor and prescale select back to their reset values.
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(DIV, 32'h000000FF, OK);
    rd(PSC, 32'h00000000, OK);
    final_report;
  end
  // Watchdog sized for about eighty thousand cycles.
  initial begin
    #4000000;
    error_cnt++;
    final_report;
  end
endmodule // testbench
